// ### core/qcti_timer_unit.sv
// How it works
// [RULE_01] Mode 3: up on A falling with B high, down on B falling with A high.
// [RULE_02] Mode 4: counts only on B edges, direction from A level.
// [RULE_03] Channels 1 and 5 use pins a/b; channels 2 and 4 use pins c/d.
// [RULE_04] Encoder channels also offer phase mode 1 on their pin pair.
// [RULE_05] A compare match on a chosen general register clears the counter.
// [RULE_06] Register B capture may follow the coupled channel's count clock.
// [RULE_07] Encoder registers A/B capture on coupled compare matches A/C.
// [RULE_08] Match, overflow and underflow sources each own a flag and enable.
// [RULE_09] Events set flags regardless of enable; request is flag and enable.
// [RULE_10] A request holds until its flag is cleared, then withdraws.
// [RULE_11] Priority among sources of a channel is fixed A,B,C,D,ovf,unf.
// [RULE_12] Channels 0 and 3 own A-D and overflow; others A,B, ovf, unf.
// [RULE_13] Only the register A source can request a DMA transfer.
// [RULE_14] Request outputs are ordered by channel; a second unit mirrors.
// [RULE_15] Reduced variant drops input capture on channels 4 and 5.
// [RULE_16] Phase modes exist only on channels 1, 2, 4, 5, ignoring prescaler.
// [RULE_17] Up wrap sets overflow, down wrap sets underflow.
// [RULE_18] A read-only direction flag shows the last count direction.
// [RULE_19] Software clears a flag by reading 1 then writing 0; DMA auto-clears.
// [RULE_20] Phase pins are synchronised and edge detected on the clock.
// [RULE_21] Edges on both phases in one cycle leave the counter alone.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "qcti_defines.svh"
module qcti_timer_unit
  import qcti_pkg::*;
#(
  parameter bit REDUCED = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Encoder phase pins
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  input wire logic ext_clock_pin_c,
  input wire logic ext_clock_pin_d,
  // DMA controller
  input wire logic [5:0] dma_ack,
  output logic [5:0] dma_req,
  // Interrupt requests, bit n belongs to channel n; irq_top_src holds bits 3n to 3n+2 for channel n
  output logic [5:0] irq_reg_a,
  output logic [5:0] irq_reg_b,
  output logic [5:0] irq_reg_c,
  output logic [5:0] irq_reg_d,
  output logic [5:0] irq_overflow,
  output logic [5:0] irq_underflow,
  output logic [5:0] irq_any,
  output logic [17:0] irq_top_src
);

  qcti_state_t r;
  qcti_state_t n;
  logic [5:0] ph_up;
  logic [5:0] ph_dn;
  logic [5:0] up;
  logic [5:0] dn;
  logic [5:0][3:0] match;
  logic [5:0][3:0] cap;
  logic wr_go;
  logic rd_go;
  logic [2:0] bsel;
  logic [2:0] bidx;
  logic [31:0] rv;

  // Channel has general registers C and D
  function automatic logic four_reg(input int c);
    return (c == 0) || (c == 3);
  endfunction

  // Sources present on a channel
  function automatic logic [5:0] src_mask(input int c);
    return four_reg(c) ? `QCTI_SRC_MASK4 : `QCTI_SRC_MASK2; // [RULE_12]
  endfunction

  // Byte lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Internal count enable from the shared divider
  function automatic logic psc_tick(input logic [1:0] sel,
    input logic [5:0] div);
    logic t;
    t = 1'b1;
    unique case (sel)
      2'h0: t = 1'b1;
      2'h1: t = div[1:0] == `QCTI_PSC_DIV4;
      2'h2: t = div[3:0] == `QCTI_PSC_DIV16;
      2'h3: t = div == `QCTI_PSC_DIV64;
    endcase
    return t;
  endfunction

  // Highest pending source inside one channel
  function automatic logic [2:0] prio(input logic [5:0] req);
    logic [2:0] s;
    s = `QCTI_TOP_NONE;
    for (int i = 5; i >= 0; i--)
      if (req[i])
        s = 3'(i); // [RULE_11]
    return s;
  endfunction

  // One phase decoder per channel on its own pin pair
  for (genvar g = 0; g < 6; g++)
  begin : g_dec
    localparam int PA = (g == 2 || g == 4) ? 2 : 0; // [RULE_03]
    qcti_phase_decode u_dec (
      .mode(qcti_mode_t'(r.ctrl[g][`QCTI_CTL_MODE])),
      .a(r.sync2[PA]),
      .b(r.sync2[PA + 1]),
      .a_prev(r.prev[PA]),
      .b_prev(r.prev[PA + 1]),
      .up(ph_up[g]),
      .dn(ph_dn[g])
    );
  end

  // Register select and accepted bus cycles, kept out of the state logic
  assign bsel = address[7:5];
  assign bidx = address[4:2];
  assign wr_go = write && !r.waitrequest;
  assign rd_go = read && !r.waitrequest;

  // Read data mux for the addressed register
  always_comb
  begin
    rv = 32'h0000_0000;
    if (bsel < `QCTI_NUM_CH)
    begin
      unique case (bidx)
        `QCTI_IDX_CTRL: rv = {17'h0_0000, r.ctrl[bsel]};
        `QCTI_IDX_IER: rv = {26'h000_0000, r.ier[bsel]};
        `QCTI_IDX_STS: rv = {24'h00_0000, r.dir[bsel], 1'b0,
          r.sts[bsel]}; // [RULE_18]
        `QCTI_IDX_CNT: rv = {16'h0000, r.cnt[bsel]};
        default:
          if (bidx[1] == 1'b0 || four_reg(int'(bsel)))
            rv = {16'h0000, r.gr[bsel][bidx[1:0]]};
      endcase
    end
  end

  // Next state of the whole unit
  always_comb
  begin
    int p;
    logic run;
    logic phase;
    logic clear;
    logic [2:0] cs;
    logic [3:0] mc;
    logic [5:0] ev;
    logic [5:0] clr;
    logic [15:0] w;
    p = 0;
    run = 1'b0;
    phase = 1'b0;
    clear = 1'b0;
    cs = `QCTI_CLR_NONE;
    mc = 4'h0;
    ev = 6'h00;
    clr = 6'h00;
    w = 16'h0000;
    n = r;
    up = 6'h00;
    dn = 6'h00;
    match = '0;
    cap = '0;
    n.div = r.div + 6'h01;
    // Two-stage pin synchroniser and previous sample
    n.sync1 = {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_b,
      ext_clock_pin_a}; // [RULE_20]
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    // Count steps and compare matches
    for (int c = 0; c < 6; c++)
    begin
      run = r.ctrl[c][`QCTI_CTL_RUN];
      phase = r.ctrl[c][`QCTI_CTL_MODE] != QCTI_MODE_NORMAL;
      up[c] = run && (phase ? ph_up[c]
        : psc_tick(r.ctrl[c][`QCTI_CTL_PSC], r.div)); // [RULE_16]
      dn[c] = run && phase && ph_dn[c];
      for (int k = 0; k < 4; k++)
        match[c][k] = (up[c] || dn[c]) && r.cnt[c] == r.gr[c][k]
          && !r.ctrl[c][`QCTI_CTL_CAP_LSB + k]
          && (k < 2 || four_reg(c));
    end
    // Capture triggers from the coupled channel
    for (int c = 0; c < 6; c++)
    begin
      p = four_reg(c) ? c + 1 : c - 1;
      if (r.ctrl[c][`QCTI_CTL_LINK] && !(REDUCED && c >= 4)) // [RULE_15]
      begin
        if (four_reg(c))
          cap[c][1] = up[p] || dn[p]; // [RULE_06]
        else if (c == 1 || c == 4)
        begin
          cap[c][0] = match[p][0]; // [RULE_07]
          cap[c][1] = match[p][2]; // [RULE_07]
        end
      end
      cap[c] = cap[c] & r.ctrl[c][`QCTI_CTL_CAP_LSB +: 4];
    end
    // Counter, capture registers and flags per channel
    for (int c = 0; c < 6; c++)
    begin
      mc = match[c] | cap[c];
      cs = r.ctrl[c][`QCTI_CTL_CLR];
      clear = cs != `QCTI_CLR_NONE && cs <= `QCTI_CLR_MAX
        && mc[cs[1:0] - 2'h1]; // [RULE_05]
      if (clear)
        n.cnt[c] = `QCTI_CNT_RST;
      else if (up[c])
        n.cnt[c] = r.cnt[c] + 16'h0001;
      else if (dn[c])
        n.cnt[c] = r.cnt[c] - 16'h0001;
      if (up[c])
        n.dir[c] = 1'b1; // [RULE_18]
      else if (dn[c])
        n.dir[c] = 1'b0;
      for (int k = 0; k < 4; k++)
        if (cap[c][k])
          n.gr[c][k] = r.cnt[c];
      if (cap[c][1] && four_reg(c) && r.ctrl[c][`QCTI_CTL_BUF])
        n.gr[c][3] = r.gr[c][1]; // [RULE_06]
      ev = {dn[c] && !clear && r.cnt[c] == 16'h0000,
        up[c] && !clear && r.cnt[c] == 16'hFFFF, mc}; // [RULE_17]
      ev = ev & src_mask(c); // [RULE_08]
      // Software writes
      clr = 6'h00;
      if (wr_go && bsel == 3'(c))
      begin
        unique case (bidx)
          `QCTI_IDX_CTRL:
          begin
            w = merge16({1'b0, r.ctrl[c]}, writedata, byteenable);
            if (w[2:0] > 3'(QCTI_MODE_PH4)
                || (four_reg(c) && w[2:0] != 3'(QCTI_MODE_NORMAL)))
              w[2:0] = 3'(QCTI_MODE_NORMAL); // [RULE_16]
            n.ctrl[c] = w[14:0];
          end
          `QCTI_IDX_IER:
            if (byteenable[0])
              n.ier[c] = writedata[5:0] & src_mask(c); // [RULE_08]
          `QCTI_IDX_STS:
          begin
            if (byteenable[0])
              clr = r.rd_one[c] & ~writedata[5:0]; // [RULE_19]
            n.rd_one[c] = `QCTI_FLAG_RST;
          end
          `QCTI_IDX_CNT:
            if (!clear)
              n.cnt[c] = merge16(r.cnt[c], writedata, byteenable);
          default:
            if (bidx[1] == 1'b0 || four_reg(c))
              n.gr[c][bidx[1:0]] = merge16(r.gr[c][bidx[1:0]],
                writedata, byteenable);
        endcase
      end
      if (rd_go && bsel == 3'(c) && bidx == `QCTI_IDX_STS)
        n.rd_one[c] = r.readdata[5:0]; // [RULE_19]
      if (dma_ack[c])
        clr[`QCTI_ST_A] = 1'b1; // [RULE_19]
      // Set wins over clear
      n.sts[c] = (r.sts[c] & ~clr) | ev; // [RULE_09]
      n.irq[c] = n.sts[c] & n.ier[c]; // [RULE_09] [RULE_10]
      n.dma_req[c] = n.irq[c][`QCTI_ST_A]; // [RULE_13]
      n.irq_any[c] = |n.irq[c];
      n.top[c] = prio(n.irq[c]); // [RULE_11]
    end
    // Bus handshake: one wait cycle, then a single accept cycle
    if ((read || write) && r.waitrequest)
    begin
      n.waitrequest = 1'b0;
      if (read)
        n.readdata = rv;
    end
    else
      n.waitrequest = 1'b1;
  end

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.cnt <= {6{`QCTI_CNT_RST}};
      r.gr <= {24{`QCTI_GR_RST}};
      r.ctrl <= {6{`QCTI_CTRL_RST}};
      r.waitrequest <= 1'b1;
      r.top <= {6{`QCTI_TOP_NONE}};
    end
    else
      r <= n;
  end

  // Outputs straight from the state register
  assign readdata = r.readdata;
  assign waitrequest = r.waitrequest;
  assign dma_req = r.dma_req;
  assign irq_any = r.irq_any;
  for (genvar g = 0; g < 6; g++)
  begin : g_out
    assign irq_reg_a[g] = r.irq[g][0]; // [RULE_14]
    assign irq_reg_b[g] = r.irq[g][1];
    assign irq_reg_c[g] = r.irq[g][2];
    assign irq_reg_d[g] = r.irq[g][3];
    assign irq_overflow[g] = r.irq[g][`QCTI_ST_OVF];
    assign irq_underflow[g] = r.irq[g][`QCTI_ST_UNF];
    assign irq_top_src[3 * g +: 3] = r.top[g];
  end

endmodule

// ### core/qcti_defines.svh
`ifndef QCTI_DEFINES_SVH
`define QCTI_DEFINES_SVH

// Word index of each register inside a channel block of eight words
`define QCTI_IDX_CTRL 3'h0
`define QCTI_IDX_IER 3'h1
`define QCTI_IDX_STS 3'h2
`define QCTI_IDX_CNT 3'h3
`define QCTI_IDX_GRA 3'h4
`define QCTI_NUM_CH 3'h6

// Control register fields
`define QCTI_CTL_MODE 2:0
`define QCTI_CTL_PSC 4:3
`define QCTI_CTL_RUN 5
`define QCTI_CTL_CLR 8:6
`define QCTI_CTL_CAP_LSB 9
`define QCTI_CTL_BUF 13
`define QCTI_CTL_LINK 14

// Status and enable bit positions
`define QCTI_ST_A 0
`define QCTI_ST_OVF 4
`define QCTI_ST_UNF 5
`define QCTI_ST_DIR 7

// Reset values
`define QCTI_CNT_RST 16'h0000
`define QCTI_GR_RST 16'hFFFF
`define QCTI_CTRL_RST 15'h0000
`define QCTI_FLAG_RST 6'h00

// Sources that exist per channel kind
`define QCTI_SRC_MASK4 6'h1F
`define QCTI_SRC_MASK2 6'h33

// Clear select and prescaler terminal counts
`define QCTI_CLR_NONE 3'h0
`define QCTI_CLR_MAX 3'h4
`define QCTI_PSC_DIV4 6'h03
`define QCTI_PSC_DIV16 6'h0F
`define QCTI_PSC_DIV64 6'h3F
`define QCTI_TOP_NONE 3'h7

`endif

// ### core/qcti_pkg.sv
package qcti_pkg;

  // Counting modes held in the control register mode field
  typedef enum logic [2:0]
  {
    QCTI_MODE_NORMAL,
    QCTI_MODE_PH1,
    QCTI_MODE_PH2,
    QCTI_MODE_PH3,
    QCTI_MODE_PH4
  } qcti_mode_t;

  // Whole state of the timer unit
  typedef struct packed {
    logic [5:0][15:0] cnt;
    logic [5:0][3:0][15:0] gr;
    logic [5:0][14:0] ctrl;
    logic [5:0][5:0] ier;
    logic [5:0][5:0] sts;
    logic [5:0][5:0] rd_one;
    logic [5:0] dir;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [5:0] div;
    logic waitrequest;
    logic [31:0] readdata;
    logic [5:0][5:0] irq;
    logic [5:0] dma_req;
    logic [5:0] irq_any;
    logic [5:0][2:0] top;
  } qcti_state_t;

endpackage

// ### core/qcti_phase_decode.sv
`timescale 1ns/10ps
module qcti_phase_decode
  import qcti_pkg::*;
(
  // Mode
  input wire qcti_mode_t mode,
  // Phase levels now and one cycle earlier
  input wire logic a,
  input wire logic b,
  input wire logic a_prev,
  input wire logic b_prev,
  // Count steps
  output logic up,
  output logic dn
);

  logic ar;
  logic af;
  logic br;
  logic bf;
  logic both;

  // Edge detection in the clock domain
  assign ar = a & ~a_prev;
  assign af = ~a & a_prev;
  assign br = b & ~b_prev;
  assign bf = ~b & b_prev;
  assign both = (a ^ a_prev) & (b ^ b_prev);

  // Count conditions per mode; simultaneous edges count nothing
  always_comb
  begin
    up = 1'b0;
    dn = 1'b0;
    if (!both) // [RULE_21]
    begin
      unique case (mode)
        QCTI_MODE_NORMAL:
        begin
          up = 1'b0;
          dn = 1'b0;
        end
        QCTI_MODE_PH1:
        begin
          up = (a & br) | (~a & bf) | (ar & ~b) | (af & b); // [RULE_04]
          dn = (a & bf) | (~a & br) | (ar & b) | (af & ~b); // [RULE_04]
        end
        QCTI_MODE_PH2:
        begin
          up = af & b;
          dn = af & ~b;
        end
        QCTI_MODE_PH3:
        begin
          up = af & b; // [RULE_01]
          dn = bf & a; // [RULE_01]
        end
        QCTI_MODE_PH4:
        begin
          up = (a & br) | (~a & bf); // [RULE_02]
          dn = (a & bf) | (~a & br); // [RULE_02]
        end
        default:
        begin
          up = 1'b0;
          dn = 1'b0;
        end
      endcase
    end
  end

endmodule

// ### sim/qcti_chk.sv
`timescale 1ns/10ps
module qcti_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Requests
  input wire logic [5:0] dma_ack,
  input wire logic [5:0] dma_req,
  input wire logic [5:0] irq_reg_a,
  input wire logic [5:0] irq_reg_b,
  input wire logic [5:0] irq_reg_c,
  input wire logic [5:0] irq_reg_d,
  input wire logic [5:0] irq_overflow,
  input wire logic [5:0] irq_underflow,
  input wire logic [5:0] irq_any,
  input wire logic [17:0] irq_top_src
);
  // One clock domain, gated by reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Bus answer timing
  a_bus_one_wait: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("no answer after one wait");
  a_bus_short_ans: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  a_unmapped_zero: assert property (read && !waitrequest
    && address >= 8'hC0 |-> readdata == 32'h0) else $error("bad read");
  // Request structure
  a_dma_only_a: assert property (dma_req == irq_reg_a)
    else $error("dma request not tied to source a");
  a_no_cd_src: assert property (((irq_reg_c | irq_reg_d) & 6'h36)
    == 6'h00) else $error("c or d on two-source channel");
  a_no_unf_src: assert property ((irq_underflow & 6'h09) == 6'h00)
    else $error("underflow on channel 0 or 3");
  a_any_is_or: assert property (irq_any == (irq_reg_a | irq_reg_b
    | irq_reg_c | irq_reg_d | irq_overflow | irq_underflow))
    else $error("summary request wrong");
  a_prio_a_first: assert property (irq_reg_a[1]
    |-> irq_top_src[5:3] == 3'h0) else $error("source a not first");
  a_irq_holds: assert property (irq_overflow[1] && !write
    |=> irq_overflow[1]) else $error("request dropped");
  a_dma_clears: assert property (dma_ack[1] && dma_req[1]
    |=> !dma_req[1]) else $error("dma ack did not clear");
  // Main scenarios
  c_dma: cover property ($rose(dma_req[1]));
  c_ovf: cover property ($rose(irq_overflow[1]));
  c_unf: cover property ($rose(irq_underflow[1]));
endmodule

bind qcti_timer_unit qcti_chk i_chk (.clk, .rstn, .address, .read,
  .write, .readdata, .waitrequest, .dma_ack, .dma_req, .irq_reg_a,
  .irq_reg_b, .irq_reg_c, .irq_reg_d, .irq_overflow, .irq_underflow,
  .irq_any, .irq_top_src);

// ### sim/qcti_encoder.sv
`timescale 1ns/10ps
module qcti_encoder
(
  // Clock
  input wire logic clk,
  // Phase pins a, b, c, d
  output logic [3:0] pins
);
  // Encoder rests with all phases high
  initial pins = 4'hF;

  // Move phases after an edge, then hold past the pin filter
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    pins <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ### sim/test_quadrature_count_and_timer_irq.sv
`timescale 1ns/10ps
module test_quadrature_count_and_timer_irq;
  logic clk, rstn, read, write, waitrequest;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd, s1;
  logic [3:0] pins;
  logic [5:0] dma_ack, dma_req, irq_reg_a, irq_reg_b, irq_reg_c;
  logic [5:0] irq_reg_d, irq_overflow, irq_underflow, irq_any;
  logic [17:0] irq_top_src;
  logic [15:0] exp_cnt [4];
  logic [7:0] base [4] = '{8'h20, 8'hA0, 8'h40, 8'h80};
  logic [3:0] seq [14] = '{4'h7, 4'hF, 4'hB, 4'h3, 4'h2, 4'h0, 4'h1,
    4'h4, 4'hC, 4'hF, 4'h3, 4'h7, 4'hF, 4'hD};
  int errors, checks, cyc;

  qcti_timer_unit i_dut (.clk, .rstn, .address, .read, .write,
    .byteenable(4'hF), .writedata, .readdata, .waitrequest,
    .ext_clock_pin_a(pins[3]), .ext_clock_pin_b(pins[2]),
    .ext_clock_pin_c(pins[1]), .ext_clock_pin_d(pins[0]), .dma_ack,
    .dma_req, .irq_reg_a, .irq_reg_b, .irq_reg_c, .irq_reg_d,
    .irq_overflow, .irq_underflow, .irq_any, .irq_top_src);
  qcti_encoder i_enc (.clk, .pins);

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize;
    end
  end

  task summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access, held until the answer edge
  task automatic bus(input logic wr, input logic [7:0] ad,
    input logic [31:0] wd);
    @(posedge clk);
    address <= ad;
    write <= wr;
    read <= !wr;
    writedata <= wd;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Expected count step from phase levels {a,b} before and after
  function automatic logic [15:0] dlt(input logic m4,
    input logic [1:0] p, input logic [1:0] n);
    if (p[1] != n[1] && p[0] != n[0])
      return 16'h0000;
    if (m4)
      return (p[0] == n[0]) ? 16'h0000 :
        ((n[0] ^ n[1]) ? 16'hFFFF : 16'h0001);
    if (p[1] && !n[1] && n[0])
      return 16'h0001;
    if (p[0] && !n[0] && n[1])
      return 16'hFFFF;
    return 16'h0000;
  endfunction

  // Move the encoder and compare all four counters
  task automatic ph(input logic [3:0] v);
    logic [3:0] p;
    p = pins;
    i_enc.drive(v);
    for (int k = 0; k < 4; k++)
    begin
      exp_cnt[k] += dlt(k[0], k < 2 ? p[3:2] : p[1:0],
        k < 2 ? v[3:2] : v[1:0]);
      bus(1'b0, base[k] + 8'h0C, 32'h0);
      chk(rd, {16'h0000, exp_cnt[k]});
    end
  endtask

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    dma_ack = 6'h00;
    exp_cnt = '{default: 16'h0000};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0000FFFF);
    for (int m = 0; m < 8; m++)
    begin
      bus(1'b1, 8'h20, m);
      bus(1'b0, 8'h20, 32'h0);
      chk(rd, m < 5 ? m : 0);
    end
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'hC0, 32'h1);
    bus(1'b0, 8'hC0, 32'h0);
    chk(rd, 32'h0);
    $display("registers done");
    // Modes 3 and 4 on both pin pairs, running
    for (int k = 0; k < 4; k++)
      bus(1'b1, base[k], k[0] ? 32'h24 : 32'h23);
    foreach (seq[i])
      ph(seq[i]);
    ph(4'hF);
    $display("counting done");
    // Flags, requests and clearing
    ph(4'hB);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd & 32'h20, 32'h20);
    chk(irq_underflow, 6'h00);
    bus(1'b1, 8'h24, 32'h31);
    @(negedge clk);
    chk(irq_underflow, 6'h02);
    ph(4'hF);
    chk(irq_underflow, 6'h02);
    bus(1'b0, 8'h28, 32'h0);
    bus(1'b1, 8'h28, 32'h0);
    @(negedge clk);
    chk(irq_underflow, 6'h00);
    ph(4'h7);
    bus(1'b0, 8'h28, 32'h0);
    s1 = rd;
    chk(rd & 32'h11, 32'h11);
    chk(irq_overflow, 6'h02);
    chk(dma_req, 6'h02);
    chk(irq_top_src[5:3], 3'h0);
    @(posedge clk);
    dma_ack <= 6'h02;
    @(posedge clk);
    dma_ack <= 6'h00;
    @(negedge clk);
    chk(dma_req, 6'h00);
    chk(irq_top_src[5:3], 3'h4);
    ph(4'hF);
    ph(4'hB);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd[7] ^ s1[7], 1'b1);
    $display("flags done");
    // Channel 0 clears on match C; captures couple channels 0 and 1
    bus(1'b1, 8'h2C, 32'h0123);
    exp_cnt[0] = 16'h0123;
    bus(1'b1, 8'h20, 32'h4623);
    bus(1'b1, 8'h18, 32'h0002);
    bus(1'b1, 8'h00, 32'h64E0);
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd < 32'h3, 1'b1);
    bus(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h0123);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h6, 32'h4);
    // Two steps of channel 1 capture twice into B; buffer moves B to D
    ph(4'hF);
    ph(4'h7);
    ph(4'hF);
    ph(4'hB);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd < 32'h3, 1'b1);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd < 32'h3, 1'b1);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h6, 32'h6);
    $display("capture done");
    // Phase mode 1 on channel 2: one forward cycle of c/d counts four
    bus(1'b1, 8'h40, 32'h21);
    i_enc.drive(4'h9);
    i_enc.drive(4'h8);
    i_enc.drive(4'hA);
    i_enc.drive(4'hB);
    bus(1'b0, 8'h4C, 32'h0);
    chk(rd, {16'h0000, exp_cnt[2] + 16'h0004});
    $display("phase mode 1 done");
    summarize;
  end
endmodule
